// >>> core/fmc_top.sv
// Frame metadata generator and vertical frame combiner.
// Behaviour
// - Sixteen-bit frame counter advances per frame.
// - Trigger enabled: clear at start, wrap burst.
// - Trigger disabled: counter runs freely, wraps.
// - Time counter ticks; cleared on acquisition start.
// - Frame start latches time as stamp.
// - Tick period selected by decade exponent.
// - Frame start latches 32-bit encoder position.
// - Frame start snapshots port levels.
// - Burst counter increments per accepted trigger.
// - Frame start latches active settings page.
// - Global enable plus per-field metadata selects.
// - Combiner stacks frames top to bottom.
// - Pixels pass straight through; image end flagged only after all tiles acquired or flush-filled.
// - Flush emits image, missing tiles black.
// - Flush by command or timeout.
// - Timeout in ms since frame; zero disables.
// - Accepted trigger starts configured frame burst.
`timescale 1ns/1ps
module fmc_top #(
    parameter int PORTS = 8,
    parameter int PAGE_W = 4,
    parameter int PIX_W = 16,
    parameter int TILE_W = 8,
    parameter int US_CYCLES = fmc_pkg::TICK_US_CYCLES
) (
    input wire logic CLK, // Processing clock.
    input wire logic SRST, // Synchronous reset.
    input wire logic ACQUIRE, // Acquisition running level.
    input wire logic ACQUISITION_BEGIN_TRIGGER_EN, // Acquisition-start trigger enabled.
    input wire logic ACQUISITION_BEGIN_TRIGGER, // Acquisition-start trigger pulse.
    input wire logic [fmc_pkg::FRAME_W-1:0] BURST_FRAME_COUNT, // Frames per burst.
    input wire logic FRAME_START, // Frame-start trigger pulse.
    input wire logic [fmc_pkg::POS_W-1:0] SHAFT_POSITION_VALUE, // Encoder position counter.
    input wire logic [PORTS-1:0] GENERAL_IO_PORT, // Port pin levels.
    input wire logic [PAGE_W-1:0] ACTIVE_SETTINGS_PAGE, // Active sequencer page.
    input wire logic signed [fmc_pkg::EXP_W-1:0] TIME_UNIT_EXPONENT, // Tick unit exponent.
    input wire logic METADATA_GLOBAL_ENABLE, // Metadata append enable.
    input wire logic [fmc_pkg::NUM_FIELDS-1:0] METADATA_FIELD_SELECT, // Per-field enables.
    input wire logic [TILE_W-1:0] TILE_COUNT, // Frames per combined image.
    input wire logic [15:0] AUTOFLUSH_TIMEOUT_MS, // Idle timeout, zero disables.
    input wire logic MANUAL_FLUSH_COMMAND, // Flush pulse.
    input wire logic [23:0] FRAME_PIXELS, // Pixels per input frame.
    input wire logic PIX_IN_VALID, // Input pixel valid.
    input wire logic [PIX_W-1:0] PIX_IN_DATA, // Input pixel.
    input wire logic PIX_IN_LAST, // Last pixel of input frame.
    output logic PIX_IN_READY, // Combiner accepts pixels.
    output logic PIX_OUT_VALID, // Output pixel valid.
    output logic [PIX_W-1:0] PIX_OUT_DATA, // Output pixel.
    output logic PIX_OUT_LAST, // Last pixel of output image.
    output logic META_VALID, // Metadata record pulse.
    output logic [fmc_pkg::FRAME_W-1:0] FRAME_SEQUENCE_COUNT, // Frame number field.
    output logic [fmc_pkg::TIME_W-1:0] FRAME_TIME_STAMP, // Time stamp field.
    output logic [fmc_pkg::POS_W-1:0] FRAME_SHAFT_POSITION, // Position field.
    output logic [PORTS-1:0] PORT_LEVEL_SNAPSHOT, // Port level field.
    output logic [fmc_pkg::BURST_W-1:0] BURST_SEQUENCE_COUNT, // Burst number field.
    output logic [PAGE_W-1:0] FRAME_SETTINGS_PAGE, // Page field.
    output logic BURST_ACTIVE // Burst in progress.
);
    // ==========================================================
    // Time base and port synchroniser
    logic unit_tick;
    logic ms_tick;
    logic [PORTS-1:0] port_level;

    fmc_tick_gen #(.US_CYCLES(US_CYCLES)) u_tick (
        .clk(CLK),
        .srst(SRST),
        .exponent(TIME_UNIT_EXPONENT),
        .unit_tick(unit_tick),
        .ms_tick(ms_tick)
    );

    fmc_sync3 #(.WIDTH(PORTS)) u_sync (
        .clk(CLK),
        .srst(SRST),
        .async_in(GENERAL_IO_PORT),
        .level(port_level)
    );

    // ==========================================================
    // Acquisition and counters
    logic acquire_d;
    logic [fmc_pkg::FRAME_W-1:0] frame_cnt;
    logic [fmc_pkg::FRAME_W-1:0] burst_left;
    logic [fmc_pkg::TIME_W-1:0] time_cnt;
    logic [fmc_pkg::BURST_W-1:0] burst_cnt;
    wire acq_begin = ACQUIRE && !acquire_d;
    // A trigger is accepted only while no burst is running.
    wire trig_ok = ACQUIRE && ACQUISITION_BEGIN_TRIGGER_EN && ACQUISITION_BEGIN_TRIGGER && !BURST_ACTIVE;
    wire frame_ok = FRAME_START && ACQUIRE && (!ACQUISITION_BEGIN_TRIGGER_EN || BURST_ACTIVE);
    wire frame_wrap = ACQUISITION_BEGIN_TRIGGER_EN && (frame_cnt >= BURST_FRAME_COUNT - 16'h0001);
    wire [fmc_pkg::FRAME_W-1:0] next_frame = frame_wrap ? fmc_pkg::FRAME_RST : frame_cnt + 16'h0001;
    wire burst_end = frame_ok && ACQUISITION_BEGIN_TRIGGER_EN && (burst_left <= 16'h0001);
    wire meta_on = METADATA_GLOBAL_ENABLE;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            acquire_d <= 1'b0;
            frame_cnt <= fmc_pkg::FRAME_RST;
            time_cnt <= fmc_pkg::TIME_RST;
            burst_cnt <= fmc_pkg::BURST_RST;
            burst_left <= '0;
            BURST_ACTIVE <= 1'b0;
        end
        else
        begin
            acquire_d <= ACQUIRE;
            if (acq_begin || trig_ok)
                frame_cnt <= fmc_pkg::FRAME_RST;
            else if (frame_ok)
                frame_cnt <= next_frame;
            if (acq_begin)
                time_cnt <= fmc_pkg::TIME_RST;
            else if (unit_tick)
                time_cnt <= time_cnt + 16'h0001;
            if (trig_ok)
                burst_cnt <= burst_cnt + 16'h0001;
            if (trig_ok)
            begin
                BURST_ACTIVE <= 1'b1;
                burst_left <= BURST_FRAME_COUNT;
            end
            else if (burst_end || !ACQUIRE || !ACQUISITION_BEGIN_TRIGGER_EN)
                BURST_ACTIVE <= 1'b0;
            else if (frame_ok)
                burst_left <= burst_left - 16'h0001;
        end
    end

    // ==========================================================
    // Metadata capture at frame start
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            META_VALID <= 1'b0;
            FRAME_SEQUENCE_COUNT <= '0;
            FRAME_TIME_STAMP <= '0;
            FRAME_SHAFT_POSITION <= '0;
            PORT_LEVEL_SNAPSHOT <= '0;
            BURST_SEQUENCE_COUNT <= '0;
            FRAME_SETTINGS_PAGE <= '0;
        end
        else
        begin
            META_VALID <= frame_ok && meta_on;
            if (frame_ok)
            begin
                // Unselected fields read as zero so the host can pack only what it asked for.
                FRAME_SEQUENCE_COUNT <= METADATA_FIELD_SELECT[fmc_pkg::FLD_FRAME] ? frame_cnt : '0;
                FRAME_TIME_STAMP <= METADATA_FIELD_SELECT[fmc_pkg::FLD_TIME] ? time_cnt : '0;
                FRAME_SHAFT_POSITION <= METADATA_FIELD_SELECT[fmc_pkg::FLD_POS] ? SHAFT_POSITION_VALUE : '0;
                PORT_LEVEL_SNAPSHOT <= METADATA_FIELD_SELECT[fmc_pkg::FLD_PORTS] ? port_level : '0;
                BURST_SEQUENCE_COUNT <= METADATA_FIELD_SELECT[fmc_pkg::FLD_BURST] ? burst_cnt : '0;
                FRAME_SETTINGS_PAGE <= METADATA_FIELD_SELECT[fmc_pkg::FLD_PAGE] ? ACTIVE_SETTINGS_PAGE : '0;
            end
        end
    end

    // ==========================================================
    // Frame combiner
    fmc_pkg::fmc_state_type state;
    logic [TILE_W-1:0] tile_idx;
    logic in_frame;
    logic flush_pend;
    logic [31:0] fill_cnt;
    logic [15:0] idle_ms;
    wire combine_on = (TILE_COUNT > 8'(1));
    wire take = PIX_IN_VALID && PIX_IN_READY && (state == fmc_pkg::ST_PASS);
    wire last_tile = !combine_on || (tile_idx == TILE_COUNT - 8'(1));
    wire timeout_hit = (AUTOFLUSH_TIMEOUT_MS != 16'h0000) && (idle_ms >= AUTOFLUSH_TIMEOUT_MS);
    wire partial = (tile_idx != '0) && !in_frame;
    // Flush waits for a gap in the input so that a frame is never cut in half.
    wire start_fill = flush_pend && partial && !PIX_IN_VALID && (state == fmc_pkg::ST_PASS);
    wire [TILE_W-1:0] tiles_left = TILE_COUNT - tile_idx;
    wire [31:0] fill_len = 32'(tiles_left * FRAME_PIXELS) - 32'h1;
    wire fill_done = (state == fmc_pkg::ST_FILL) && (fill_cnt == 32'h0);

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state <= fmc_pkg::ST_PASS;
            tile_idx <= '0;
            in_frame <= 1'b0;
            flush_pend <= 1'b0;
            fill_cnt <= '0;
            idle_ms <= '0;
            PIX_IN_READY <= 1'b1;
            PIX_OUT_VALID <= 1'b0;
            PIX_OUT_DATA <= '0;
            PIX_OUT_LAST <= 1'b0;
        end
        else
        begin
            PIX_OUT_VALID <= take || (state == fmc_pkg::ST_FILL);
            PIX_OUT_DATA <= take ? PIX_IN_DATA : '0;
            PIX_OUT_LAST <= (take && PIX_IN_LAST && last_tile) || fill_done;
            if (take)
                in_frame <= !PIX_IN_LAST;
            if (take && PIX_IN_LAST)
                tile_idx <= last_tile ? '0 : tile_idx + 8'(1);
            else if (fill_done)
                tile_idx <= '0;
            if (take || tile_idx == '0)
                idle_ms <= '0;
            else if (ms_tick && !timeout_hit)
                idle_ms <= idle_ms + 16'h0001;
            // A new request wins over the clear at the end of a fill.
            if (MANUAL_FLUSH_COMMAND || timeout_hit)
                flush_pend <= 1'b1;
            else if (fill_done || tile_idx == '0)
                flush_pend <= 1'b0;
            case (state)
                fmc_pkg::ST_PASS:
                begin
                    if (start_fill)
                    begin
                        state <= fmc_pkg::ST_FILL;
                        fill_cnt <= fill_len;
                        PIX_IN_READY <= 1'b0;
                    end
                end
                fmc_pkg::ST_FILL:
                begin
                    fill_cnt <= fill_cnt - 32'h1;
                    if (fill_done)
                    begin
                        state <= fmc_pkg::ST_PASS;
                        PIX_IN_READY <= 1'b1;
                    end
                end
                default:
                begin
                    state <= fmc_pkg::ST_PASS;
                    PIX_IN_READY <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_frame_taken;
        frame_ok && !acq_begin && !trig_ok;
    endsequence

    a_frame_wrap_burst: assert property (s_frame_taken ##0 frame_wrap |=> frame_cnt == 16'h0000)
        else $error("frame count did not wrap at burst end");
    a_frame_free_run: assert property (s_frame_taken ##0 !ACQUISITION_BEGIN_TRIGGER_EN
        |=> frame_cnt == $past(frame_cnt) + 16'h0001)
        else $error("free running frame count did not advance");
    a_time_clear: assert property (acq_begin |=> time_cnt == 16'h0000)
        else $error("time counter not cleared at start");
    a_stamp_latch: assert property (frame_ok && METADATA_FIELD_SELECT[1] |=> FRAME_TIME_STAMP == $past(time_cnt))
        else $error("time stamp not latched");
    a_pos_latch: assert property (frame_ok && METADATA_FIELD_SELECT[2]
        |=> FRAME_SHAFT_POSITION == $past(SHAFT_POSITION_VALUE))
        else $error("position not latched");
    a_burst_incr: assert property (trig_ok |=> burst_cnt == $past(burst_cnt) + 16'h0001 && BURST_ACTIVE)
        else $error("burst count did not advance");
    a_burst_hold: assert property (!ACQUISITION_BEGIN_TRIGGER_EN |=> $stable(burst_cnt))
        else $error("burst count moved while trigger disabled");
    a_meta_gate: assert property (!METADATA_GLOBAL_ENABLE |=> !META_VALID)
        else $error("metadata emitted while disabled");
    a_fill_black: assert property (state == fmc_pkg::ST_FILL |=> PIX_OUT_VALID && PIX_OUT_DATA == '0)
        else $error("fill pixel not black");
    a_fill_last: assert property (fill_done |=> PIX_OUT_LAST ##1 PIX_IN_READY)
        else $error("flushed image not closed");
    a_flush_start: assert property (start_fill |=> state == fmc_pkg::ST_FILL && !PIX_IN_READY)
        else $error("flush did not start fill");
    a_seq_capture: assert property (frame_ok && METADATA_FIELD_SELECT[fmc_pkg::FLD_FRAME]
        |=> FRAME_SEQUENCE_COUNT == $past(frame_cnt))
        else $error("frame number not latched");
    a_port_latch: assert property (frame_ok && METADATA_FIELD_SELECT[fmc_pkg::FLD_PORTS]
        |=> PORT_LEVEL_SNAPSHOT == $past(port_level))
        else $error("port levels not latched");
    a_page_latch: assert property (frame_ok && METADATA_FIELD_SELECT[fmc_pkg::FLD_PAGE]
        |=> FRAME_SETTINGS_PAGE == $past(ACTIVE_SETTINGS_PAGE))
        else $error("settings page not latched");
    a_tile_order: assert property (take
        |=> PIX_OUT_VALID && PIX_OUT_DATA == $past(PIX_IN_DATA))
        else $error("combined pixel out of order");
    a_last_gate: assert property (take && PIX_IN_LAST && !last_tile
        |=> !PIX_OUT_LAST)
        else $error("image closed before all tiles");
    a_fill_ready: assert property (state == fmc_pkg::ST_FILL
        |-> !PIX_IN_READY)
        else $error("input accepted during fill");
    a_timeout_flush: assert property (timeout_hit
        |=> flush_pend)
        else $error("timeout did not request flush");
    a_burst_end: assert property (burst_end
        |=> !BURST_ACTIVE)
        else $error("burst did not end");
endmodule

// >>> core/fmc_pkg.sv
// Shared constants and types for the frame metadata and combiner block.
package fmc_pkg;
    // ==========================================================
    // Field widths
    localparam int FRAME_W = 16;
    localparam int TIME_W = 16;
    localparam int BURST_W = 16;
    localparam int POS_W = 32;
    localparam int EXP_W = 4;
    // ==========================================================
    // Metadata field select bit positions
    localparam int FLD_FRAME = 0;
    localparam int FLD_TIME = 1;
    localparam int FLD_POS = 2;
    localparam int FLD_PORTS = 3;
    localparam int FLD_BURST = 4;
    localparam int FLD_PAGE = 5;
    localparam int NUM_FIELDS = 6;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS = 1000;
    localparam int TICK_US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int US_PER_MS = 1000;
    localparam logic signed [EXP_W-1:0] EXP_MS = -4'sd3;
    localparam logic signed [EXP_W-1:0] EXP_MIN = -4'sd6;
    localparam logic signed [EXP_W-1:0] EXP_MAX = 4'sd0;
    // ==========================================================
    // Reset values
    localparam logic [FRAME_W-1:0] FRAME_RST = 16'h0000;
    localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;
    localparam logic [BURST_W-1:0] BURST_RST = 16'h0000;
    // ==========================================================
    // Combiner states
    typedef enum logic [1:0]
    {
        ST_PASS = 2'b01,
        ST_FILL = 2'b10
    } fmc_state_type;
endpackage

// >>> core/fmc_sync3.sv
// Three-stage synchroniser for a vector of port levels.
`timescale 1ns/1ps
module fmc_sync3 #(
    parameter int WIDTH = 8
) (
    input wire logic clk, // Processing clock.
    input wire logic srst, // Synchronous reset.
    input wire logic [WIDTH-1:0] async_in, // Levels from pins.
    output logic [WIDTH-1:0] level // Filtered level.
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    wire [WIDTH-1:0] agree = ~(s2 ^ s3);
    wire [WIDTH-1:0] next_level = (agree & s3) | (~agree & level);

    // ==========================================================
    // Stages
    always_ff @(posedge clk)
    begin
        s1 <= async_in;
        s2 <= s1;
        s3 <= s2;
        if (srst)
            level <= '0;
        else
            level <= next_level;
    end
endmodule

// >>> core/fmc_tick_gen.sv
// Time base: microsecond prescaler, millisecond tick and decade-selectable unit tick.
`timescale 1ns/1ps
module fmc_tick_gen #(
    parameter int US_CYCLES = fmc_pkg::TICK_US_CYCLES
) (
    input wire logic clk, // Processing clock.
    input wire logic srst, // Synchronous reset.
    input wire logic signed [fmc_pkg::EXP_W-1:0] exponent, // Unit as power of ten seconds.
    output logic unit_tick, // One pulse per time unit.
    output logic ms_tick // One pulse per millisecond.
);
    // Microseconds per unit; out-of-range exponents fall back to the millisecond unit.
    function automatic logic [19:0] us_per_unit(input logic signed [fmc_pkg::EXP_W-1:0] e);
        case (e)
            -4'sd6: us_per_unit = 20'd1;
            -4'sd5: us_per_unit = 20'd10;
            -4'sd4: us_per_unit = 20'd100;
            -4'sd2: us_per_unit = 20'd10000;
            -4'sd1: us_per_unit = 20'd100000;
            default: us_per_unit = 20'd1000;
        endcase
    endfunction

    logic [15:0] cyc;
    logic [9:0] ms_us;
    logic [19:0] unit_us;
    logic [29:0] big_div;
    wire us_tick = (cyc == 16'(US_CYCLES - 1));
    wire [19:0] unit_lim = us_per_unit(exponent);
    wire unit_wrap = us_tick && (unit_us >= unit_lim - 20'd1);
    wire sec_mode = (exponent == fmc_pkg::EXP_MAX);
    wire ms_wrap = us_tick && (ms_us == 10'(fmc_pkg::US_PER_MS - 1));

    // ==========================================================
    // Counters
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cyc <= '0;
            ms_us <= '0;
            unit_us <= '0;
            big_div <= '0;
            unit_tick <= 1'b0;
            ms_tick <= 1'b0;
        end
        else
        begin
            cyc <= us_tick ? 16'h0000 : cyc + 16'h0001;
            ms_us <= ms_wrap ? 10'h000 : (us_tick ? ms_us + 10'h001 : ms_us);
            ms_tick <= ms_wrap;
            unit_us <= unit_wrap ? 20'h00000 : (us_tick ? unit_us + 20'h00001 : unit_us);
            // The one-second unit is counted in milliseconds to keep the unit counter narrow.
            big_div <= (ms_wrap && big_div == 30'd999) ? 30'h0 : (ms_wrap ? big_div + 30'h1 : big_div);
            unit_tick <= sec_mode ? (ms_wrap && big_div == 30'd999) : unit_wrap;
        end
    end
endmodule

// >>> testbench/fmc_host_sink.sv
// Host-side sink model that records every pixel of the combined output images.
`timescale 1ns/1ps
module fmc_host_sink #(
    parameter int PIX_W = 16
) (
    input wire logic clk, // Processing clock.
    input wire logic srst, // Synchronous reset.
    input wire logic valid, // Pixel valid.
    input wire logic [PIX_W-1:0] data, // Pixel value.
    input wire logic last // Last pixel of an image.
);
    logic [PIX_W-1:0] got[$];
    int n_last = 0;
    int last_idx = -1;
    task automatic clear();
        got.delete();
        n_last = 0;
        last_idx = -1;
    endtask
    // The link has no back-pressure, so the host must take every beat it is shown.
    always @(posedge clk)
    begin
        if (srst === 1'b0 && valid === 1'b1)
        begin
            got.push_back(data);
            if (last === 1'b1)
            begin
                n_last++;
                last_idx = got.size() - 1;
            end
        end
    end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the frame metadata generator and combiner.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, srst = 1'b1, acq = 1'b0, ten = 1'b0, trig = 1'b0, fs = 1'b0;
    logic gen = 1'b1, mflush = 1'b0, pv = 1'b0, pl = 1'b0;
    logic [15:0] bfc = 16'h0003, tmo = 16'h0000, pd = 16'h0000;
    logic [31:0] pos = 32'h0000_0000;
    logic [7:0] gio = 8'h00, tiles = 8'h01;
    logic [3:0] page = 4'h0;
    logic signed [3:0] expo = fmc_pkg::EXP_MS;
    logic [5:0] fsel = 6'h3f;
    logic [23:0] fpix = 24'h000004;
    wire rdy, ov, olast, mv, bact;
    wire [15:0] od, fn, ts, bn;
    wire [31:0] sp;
    wire [7:0] pls;
    wire [3:0] pg;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    // ==========================================================
    // Design, host model and clock
    // A short microsecond prescale keeps millisecond waits affordable in simulation.
    fmc_top #(.US_CYCLES(2)) u_fmc_top (
        .CLK(clk), .SRST(srst), .ACQUIRE(acq), .ACQUISITION_BEGIN_TRIGGER_EN(ten),
        .ACQUISITION_BEGIN_TRIGGER(trig), .BURST_FRAME_COUNT(bfc), .FRAME_START(fs),
        .SHAFT_POSITION_VALUE(pos), .GENERAL_IO_PORT(gio), .ACTIVE_SETTINGS_PAGE(page),
        .TIME_UNIT_EXPONENT(expo), .METADATA_GLOBAL_ENABLE(gen), .METADATA_FIELD_SELECT(fsel),
        .TILE_COUNT(tiles), .AUTOFLUSH_TIMEOUT_MS(tmo), .MANUAL_FLUSH_COMMAND(mflush),
        .FRAME_PIXELS(fpix), .PIX_IN_VALID(pv), .PIX_IN_DATA(pd), .PIX_IN_LAST(pl),
        .PIX_IN_READY(rdy), .PIX_OUT_VALID(ov), .PIX_OUT_DATA(od), .PIX_OUT_LAST(olast),
        .META_VALID(mv), .FRAME_SEQUENCE_COUNT(fn), .FRAME_TIME_STAMP(ts),
        .FRAME_SHAFT_POSITION(sp), .PORT_LEVEL_SNAPSHOT(pls), .BURST_SEQUENCE_COUNT(bn),
        .FRAME_SETTINGS_PAGE(pg), .BURST_ACTIVE(bact));
    fmc_host_sink u_fmc_host_sink (.clk(clk), .srst(srst), .valid(ov), .data(od), .last(olast));
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic final_report();
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_checks++;
        if (!(got >= lo && got <= hi))
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic start_acq();
        acq = 1'b0;
        @(negedge clk);
        acq = 1'b1;
        @(negedge clk);
    endtask
    // Returns in the cycle where the metadata record is presented.
    // The leading idle cycle keeps back-to-back pulses apart.
    task automatic frame_pulse();
        @(negedge clk);
        fs = 1'b1;
        @(negedge clk);
        fs = 1'b0;
    endtask
    task automatic send_frame(input logic [15:0] base);
        @(negedge clk);
        for (int i = 0; i < int'(fpix); i++)
        begin
            while (rdy !== 1'b1)
                @(negedge clk);
            pv = 1'b1;
            pd = base + 16'(i);
            pl = (i == int'(fpix) - 1);
            @(negedge clk);
        end
        pv = 1'b0;
        pl = 1'b0;
    endtask
    task automatic wait_last(input int limit);
        for (int i = 0; i < limit && u_fmc_host_sink.n_last == 0; i++)
            @(negedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_freerun();
        start_acq();
        for (int k = 0; k < 3; k++)
        begin
            pos = 32'hdead_0000 + 32'(k);
            gio = 8'h5a ^ 8'(k);
            page = 4'(k + 5);
            repeat (6) @(negedge clk);
            frame_pulse();
            chk(mv, 1);
            chk(fn, 32'(k));
            chk(sp, pos);
            chk(pls, gio);
            chk(pg, page);
            chk(bn, 0);
        end
    endtask
    task automatic t_burst();
        ten = 1'b1;
        start_acq();
        frame_pulse();
        chk(mv, 0);
        for (int b = 1; b < 3; b++)
        begin
            bfc = 16'(b + 2);
            trig = 1'b1;
            @(negedge clk);
            trig = 1'b0;
            chk(bact, 1);
            for (int k = 0; k < b + 2; k++)
            begin
                // A second trigger inside the burst must be refused.
                if (k == 1)
                    trig = 1'b1;
                frame_pulse();
                if (k == 1)
                    trig = 1'b0;
                chk(fn, 32'(k));
                chk(bn, 32'(b));
            end
            chk(bact, 0);
        end
        ten = 1'b0;
    endtask
    task automatic t_meta();
        fsel = 6'h01;
        frame_pulse();
        chk(mv, 1);
        chk(sp, 0);
        chk(pls, 0);
        chk(pg, 0);
        gen = 1'b0;
        frame_pulse();
        chk(mv, 0);
        gen = 1'b1;
        fsel = 6'h3f;
    endtask
    task automatic t_time();
        for (int e = 0; e < 3; e++)
        begin
            expo = (e == 0) ? fmc_pkg::EXP_MS : ((e == 1) ? -4'sd4 : -4'sd6);
            start_acq();
            frame_pulse();
            chk_in(ts, 0, 1);
            repeat (4998) @(negedge clk);
            frame_pulse();
            chk_in(ts, (e == 0) ? 2 : ((e == 1) ? 25 : 2500), (e == 0) ? 3 : ((e == 1) ? 26 : 2501));
        end
        expo = fmc_pkg::EXP_MS;
    endtask
    task automatic t_comb();
        // Only the main stream is fed while combining.
        tiles = 8'h03;
        u_fmc_host_sink.clear();
        for (int k = 0; k < 3; k++)
        begin
            send_frame(16'(16 * k + 1));
            if (k < 2)
                chk(u_fmc_host_sink.n_last, 0);
        end
        wait_last(20);
        chk(u_fmc_host_sink.got.size(), 12);
        for (int i = 0; i < 12 && i < u_fmc_host_sink.got.size(); i++)
            chk(u_fmc_host_sink.got[i], 32'((i / 4) * 16 + 1 + i % 4));
        chk(u_fmc_host_sink.last_idx, 11);
    endtask
    task automatic t_flush();
        u_fmc_host_sink.clear();
        fpix = 24'h000003;
        send_frame(16'h0100);
        repeat (4) @(negedge clk);
        mflush = 1'b1;
        @(negedge clk);
        mflush = 1'b0;
        wait_last(60);
        chk(u_fmc_host_sink.got.size(), 9);
        for (int i = 0; i < 9 && i < u_fmc_host_sink.got.size(); i++)
            chk(u_fmc_host_sink.got[i], (i < 3) ? 32'h100 + 32'(i) : 32'h0);
        chk(u_fmc_host_sink.last_idx, 8);
        chk(rdy, 1);
        fpix = 24'h000004;
    endtask
    task automatic t_auto();
        u_fmc_host_sink.clear();
        send_frame(16'h0200);
        repeat (5000) @(negedge clk);
        chk(u_fmc_host_sink.got.size(), 4);
        // Fewer than four idle milliseconds have passed by the next check.
        tmo = 16'h0004;
        repeat (900) @(negedge clk);
        chk(u_fmc_host_sink.got.size(), 4);
        wait_last(3000);
        chk(u_fmc_host_sink.got.size(), 12);
        chk(u_fmc_host_sink.last_idx, 11);
        tmo = 16'h0000;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        t_freerun();
        t_burst();
        t_meta();
        t_time();
        t_comb();
        t_flush();
        t_auto();
        final_report();
    end
endmodule
